// ---- inc/asdp_pkg.sv ----
// shared types and constants for the add/subtract datapath
package asdp_pkg;
  localparam int unsigned ASDP_XLEN    = 32;
  localparam int unsigned ASDP_IMM_W   = 12;
  localparam int unsigned ASDP_REG_W   = 4;
  localparam logic [3:0]  ASDP_REG_STACK_PTR   = 4'hd;
  localparam logic [3:0]  ASDP_REG_PROG_CTR    = 4'hf;
  localparam logic [1:0]  ASDP_BASE_ALIGN_BITS = 2'h0;
  localparam logic        ASDP_BRANCH_LSB    = 1'h0;
  localparam logic [31:0] ASDP_ZERO_WORD     = 32'h0000_0000;

  typedef enum logic [2:0] {
    ASDP_OP_ADD,
    ASDP_OP_ADC,
    ASDP_OP_SUB,
    ASDP_OP_SUB_BORROW,
    ASDP_OP_REV_SUB
  } asdp_op_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } asdp_flags_t;

  // one issued instruction from the decoder
  typedef struct packed {
    logic        valid;
    asdp_op_t    op;
    logic        use_imm;
    logic [11:0] twelve_bit_immediate;
    logic [31:0] flexible_second_operand;
    logic [31:0] first_operand_value;
    logic [3:0]  first_operand_register;
    logic        has_dest;
    logic [3:0]  dest_register;
    logic        set_flags;
  } asdp_req_t;

  // registered result towards register file and fetch
  typedef struct packed {
    logic        wr_en;
    logic [3:0]  wr_reg;
    logic [31:0] wr_data;
    logic        branch;
    logic [31:0] branch_target;
  } asdp_res_t;
endpackage : asdp_pkg

// ---- verilog/asdp_adder.sv ----
// 32-bit adder core with carry-in, carry-out and signed overflow
`timescale 1ns/10ps
module asdp_adder
  import asdp_pkg::*;
#(
  parameter int unsigned WIDTH = ASDP_XLEN
) (
  input  wire logic [WIDTH-1:0] a_in,
  input  wire logic [WIDTH-1:0] b_in,
  input  wire logic             cin_in,
  output logic      [WIDTH-1:0] sum_out,
  output logic                  cout_out,
  output logic                  ovf_out
);
  logic [WIDTH:0] wide;

  always_comb begin
    wide     = {1'b0, a_in} + {1'b0, b_in} + {{WIDTH{1'b0}}, cin_in};
    sum_out  = wide[WIDTH-1:0];
    cout_out = wide[WIDTH];
    // signed overflow: operands agree in sign, result differs
    ovf_out  = (a_in[WIDTH-1] == b_in[WIDTH-1]) &&
               (sum_out[WIDTH-1] != a_in[WIDTH-1]);
  end
endmodule : asdp_adder

// ---- verilog/asdp_datapath.sv ----
// add/subtract datapath: operand select, arithmetic, flags, writeback
// How it works
// - add writes first operand plus second operand or 12-bit immediate
// - 12-bit immediate 0..4095 is zero-extended to 32 bits
// - add-with-carry adds the current carry flag as carry-in
// - subtract gives first operand minus second operand or immediate
// - subtract-with-carry takes one more off when carry is clear
// - reverse subtract gives second operand minus first operand
// - no destination given means result goes back to first operand
// - with flag suffix NZCV follow result, otherwise flags hold
// - program counter as first operand has bits 1:0 forced to zero
// - add writing program counter branches with bit zero cleared
// - wide-immediate add/subtract behave as the 12-bit immediate forms
`timescale 1ns/10ps
module asdp_datapath
  import asdp_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire asdp_req_t   req_in,
  output asdp_res_t        res_out,
  output asdp_flags_t      flags_out
);
  typedef struct packed {
    asdp_res_t   res;
    asdp_flags_t flags;
  } asdp_state_t;

  asdp_state_t state;
  asdp_state_t next_state;

  logic [31:0] base;
  logic [31:0] operand_b;
  logic [31:0] adder_a;
  logic [31:0] adder_b;
  logic        adder_cin;
  logic [31:0] sum;
  logic        cout;
  logic        ovf;
  logic [3:0]  dest;
  logic        is_sub;

  always_comb begin
    base = req_in.first_operand_value;
    if (req_in.first_operand_register == ASDP_REG_PROG_CTR) begin
      base[1:0] = ASDP_BASE_ALIGN_BITS;
    end
    // wide-immediate encodings arrive here as use_imm, same path
    operand_b = req_in.use_imm ?
                {20'h0_0000, req_in.twelve_bit_immediate}
                : req_in.flexible_second_operand;
    is_sub    = 1'b0;
    adder_a   = base;
    adder_b   = operand_b;
    adder_cin = 1'b0;
    case (req_in.op)
      ASDP_OP_ADD: begin
        adder_cin = 1'b0;
      end
      ASDP_OP_ADC: begin
        adder_cin = state.flags.c;
      end
      ASDP_OP_SUB: begin
        // a - b as a + ~b + 1 so carry out reads as no-borrow
        adder_b   = ~operand_b;
        adder_cin = 1'b1;
        is_sub    = 1'b1;
      end
      ASDP_OP_SUB_BORROW: begin
        adder_b   = ~operand_b;
        adder_cin = state.flags.c;
        is_sub    = 1'b1;
      end
      ASDP_OP_REV_SUB: begin
        adder_a   = operand_b;
        adder_b   = ~base;
        adder_cin = 1'b1;
        is_sub    = 1'b1;
      end
      default: begin
        adder_cin = 1'b0;
      end
    endcase
  end

  asdp_adder #(
    .WIDTH (ASDP_XLEN)
  ) u_adder (
    .a_in     (adder_a),
    .b_in     (adder_b),
    .cin_in   (adder_cin),
    .sum_out  (sum),
    .cout_out (cout),
    .ovf_out  (ovf)
  );

  always_comb begin
    next_state = state;
    dest = req_in.has_dest ? req_in.dest_register
                           : req_in.first_operand_register;
    next_state.res.wr_en  = 1'b0;
    next_state.res.branch = 1'b0;
    if (req_in.valid) begin
      if (dest == ASDP_REG_PROG_CTR) begin
        // program counter is never written directly; an add to it becomes a branch, other ops write nothing
        next_state.res.branch        = (req_in.op == ASDP_OP_ADD);
        next_state.res.branch_target = {sum[31:1], ASDP_BRANCH_LSB};
      end else begin
        next_state.res.wr_en   = 1'b1;
        next_state.res.wr_reg  = dest;
        next_state.res.wr_data = sum;
      end
      if (req_in.set_flags) begin
        next_state.flags.n = sum[31];
        next_state.flags.z = (sum == ASDP_ZERO_WORD);
        next_state.flags.c = cout;
        next_state.flags.v = ovf;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign res_out   = state.res;
  assign flags_out = state.flags;

  // relies on the decoder keeping stack pointer and program counter out of
  // the second operand and restricting their forms; not checked here

  a_add_result: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    req_in.valid && req_in.op == ASDP_OP_ADD && !req_in.use_imm &&
    req_in.first_operand_register != ASDP_REG_PROG_CTR &&
    (req_in.has_dest ? req_in.dest_register : req_in.first_operand_register)
      != ASDP_REG_PROG_CTR
    |=> res_out.wr_en && res_out.wr_data ==
        $past(req_in.first_operand_value + req_in.flexible_second_operand))
    else $error("add result wrong");

  a_imm_zext: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    req_in.valid && req_in.op == ASDP_OP_SUB && req_in.use_imm &&
    req_in.first_operand_register != ASDP_REG_PROG_CTR &&
    req_in.has_dest && req_in.dest_register != ASDP_REG_PROG_CTR
    |=> res_out.wr_data == $past(req_in.first_operand_value -
        {20'h0_0000, req_in.twelve_bit_immediate}))
    else $error("immediate subtract wrong");

  a_adc_carry: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    req_in.valid && req_in.op == ASDP_OP_ADC && !req_in.use_imm &&
    req_in.first_operand_register != ASDP_REG_PROG_CTR &&
    req_in.has_dest && req_in.dest_register != ASDP_REG_PROG_CTR
    |=> res_out.wr_data == $past(req_in.first_operand_value +
        req_in.flexible_second_operand + {31'h0, flags_out.c}))
    else $error("add with carry wrong");

  a_borrow_sub: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    req_in.valid && req_in.op == ASDP_OP_SUB_BORROW && !req_in.use_imm &&
    req_in.first_operand_register != ASDP_REG_PROG_CTR &&
    req_in.has_dest && req_in.dest_register != ASDP_REG_PROG_CTR
    |=> res_out.wr_data == $past(req_in.first_operand_value -
        req_in.flexible_second_operand - {31'h0, !flags_out.c}))
    else $error("subtract with carry wrong");

  a_reverse_swap: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    req_in.valid && req_in.op == ASDP_OP_REV_SUB && !req_in.use_imm &&
    req_in.first_operand_register != ASDP_REG_PROG_CTR &&
    req_in.has_dest && req_in.dest_register != ASDP_REG_PROG_CTR
    |=> res_out.wr_data == $past(req_in.flexible_second_operand -
        req_in.first_operand_value))
    else $error("reverse subtract wrong");

  a_dest_default: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    req_in.valid && !req_in.has_dest &&
    req_in.first_operand_register != ASDP_REG_PROG_CTR
    |=> res_out.wr_en &&
        res_out.wr_reg == $past(req_in.first_operand_register))
    else $error("default destination wrong");

  a_flags_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !(req_in.valid && req_in.set_flags) |=> $stable(flags_out))
    else $error("flags changed without update");

  a_zero_flag: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    req_in.valid && req_in.set_flags && req_in.has_dest &&
    req_in.dest_register != ASDP_REG_PROG_CTR
    |=> flags_out.z == (res_out.wr_data == ASDP_ZERO_WORD) &&
        flags_out.n == res_out.wr_data[31])
    else $error("n or z flag wrong");

  a_pc_align: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    req_in.valid && req_in.op == ASDP_OP_ADD && req_in.use_imm &&
    req_in.first_operand_register == ASDP_REG_PROG_CTR &&
    req_in.has_dest && req_in.dest_register != ASDP_REG_PROG_CTR
    |=> res_out.wr_data == $past({req_in.first_operand_value[31:2], 2'h0} +
        {20'h0_0000, req_in.twelve_bit_immediate}))
    else $error("program counter base not aligned");

  a_pc_branch: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    req_in.valid && req_in.op == ASDP_OP_ADD && req_in.has_dest &&
    req_in.dest_register == ASDP_REG_PROG_CTR
    |=> res_out.branch && !res_out.wr_en && !res_out.branch_target[0])
    else $error("program counter write did not branch");

  a_branch_target: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    req_in.valid && req_in.op == ASDP_OP_ADD && !req_in.use_imm &&
    req_in.first_operand_register == ASDP_REG_PROG_CTR &&
    req_in.has_dest && req_in.dest_register == ASDP_REG_PROG_CTR
    |=> res_out.branch_target ==
        ($past({req_in.first_operand_value[31:2], 2'h0} +
               req_in.flexible_second_operand) & 32'hffff_fffe))
    else $error("branch target wrong");

  a_sub_carry: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    req_in.valid && req_in.op == ASDP_OP_SUB && req_in.set_flags &&
    !req_in.use_imm && req_in.first_operand_register != ASDP_REG_PROG_CTR
    |=> flags_out.c == $past(req_in.first_operand_value >=
                             req_in.flexible_second_operand))
    else $error("subtract carry not no-borrow");
endmodule : asdp_datapath

// ---- testbench/asdp_testbench.sv ----
// self-checking bench for the add/subtract datapath
`timescale 1ns/10ps
module testbench;
  import asdp_pkg::*;
  logic        clk_sys_in;
  logic        rst_in;
  asdp_req_t   req_in;
  asdp_res_t   res_out;
  asdp_flags_t flags_out;
  asdp_flags_t exp_f;
  int          miscompares;
  int          samples_checked;

  asdp_datapath dut_u (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .req_in     (req_in),
    .res_out    (res_out),
    .flags_out  (flags_out)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  // outputs right after a reset: nothing written or branched, flags clear
  task automatic check_cleared();
    check({31'h0, res_out.wr_en}, 32'h0);
    check({31'h0, res_out.branch}, 32'h0);
    check({28'h0, res_out.wr_reg}, 32'h0);
    check(res_out.wr_data, 32'h0);
    check(res_out.branch_target, 32'h0);
    check({28'h0, flags_out}, 32'h0);
  endtask : check_cleared

  // call at a falling edge; leaves valid up so the next call is back to back.
  // with ui set, b's low twelve bits are the immediate and the flexible
  // operand carries ~b, which the datapath has to ignore
  task automatic run(input asdp_op_t op, input logic [31:0] a,
                     input logic [31:0] b, input logic ui,
                     input logic [3:0] rn, input logic [3:0] rd,
                     input logic hd, input logic s);
    logic [31:0] x, bb, p, q, r;
    logic [33:0] u, w;
    logic        k, co, to_pc, is_br;
    logic [3:0]  dst;
    bb = ui ? {20'h0_0000, b[11:0]} : b;
    x = (rn == ASDP_REG_PROG_CTR) ? {a[31:2], 2'h0} : a;
    p = x;
    q = bb;
    k = 1'b0;
    case (op)
      ASDP_OP_ADC: k = exp_f.c;
      ASDP_OP_SUB_BORROW: k = !exp_f.c;
      ASDP_OP_REV_SUB: begin
        p = bb;
        q = x;
      end
      default: k = 1'b0;
    endcase
    if (op == ASDP_OP_ADD || op == ASDP_OP_ADC) begin
      u  = {2'h0, p} + {2'h0, q} + {33'h0_0000_0000, k};
      w  = {{2{p[31]}}, p} + {{2{q[31]}}, q} + {33'h0_0000_0000, k};
      co = u[32];
    end else begin
      // carry after a subtract: the unsigned difference did not go negative
      u  = {2'h0, p} - {2'h0, q} - {33'h0_0000_0000, k};
      w  = {{2{p[31]}}, p} - {{2{q[31]}}, q} - {33'h0_0000_0000, k};
      co = !u[33];
    end
    r     = u[31:0];
    dst   = hd ? rd : rn;
    to_pc = (dst == ASDP_REG_PROG_CTR);
    is_br = to_pc && (op == ASDP_OP_ADD);
    req_in = '{valid: 1'b1, op: op, use_imm: ui,
               twelve_bit_immediate: b[11:0],
               flexible_second_operand: ui ? ~b : b,
               first_operand_value: a, first_operand_register: rn,
               has_dest: hd, dest_register: rd, set_flags: s};
    if (s) begin
      // overflow: the signed result does not fit in 32 bits
      exp_f = '{r[31], r == 32'h0000_0000, co, w[32] ^ w[31]};
    end
    @(negedge clk_sys_in);
    check({31'h0, res_out.wr_en}, {31'h0, !to_pc});
    if (!to_pc) begin
      check({28'h0, res_out.wr_reg}, {28'h0, dst});
      check(res_out.wr_data, r);
    end
    check({31'h0, res_out.branch}, {31'h0, is_br});
    if (is_br) begin
      check(res_out.branch_target, {r[31:1], 1'b0});
    end
    check({28'h0, flags_out}, {28'h0, exp_f});
  endtask : run

  task automatic idle();
    req_in.valid = 1'b0;
    @(negedge clk_sys_in);
    check({31'h0, res_out.wr_en | res_out.branch}, 32'h0);
    check({28'h0, flags_out}, {28'h0, exp_f});
  endtask : idle

  task automatic t_add();
    run(ASDP_OP_ADD, 32'h5, 32'h3, 1'b0, 4'h1, 4'h2, 1'b1, 1'b0);
    run(ASDP_OP_ADD, 32'h10, 32'hfff, 1'b1, 4'h3, 4'h4, 1'b1, 1'b0);
    run(ASDP_OP_ADD, 32'h1, 32'h800, 1'b1, 4'h5, 4'h9, 1'b0, 1'b0);
    run(ASDP_OP_SUB, 32'h1000, 32'hfff, 1'b1, 4'hd, 4'hd, 1'b1,
        1'b0);
    run(ASDP_OP_ADD, 32'hffff_ffff, 32'h1, 1'b0, 4'h1, 4'h2, 1'b1,
        1'b0);
    idle();
    $display("test add done");
  endtask : t_add

  task automatic t_chain();
    run(ASDP_OP_ADD, 32'hffff_ffff, 32'h1, 1'b0, 4'h0, 4'h4, 1'b1,
        1'b1);
    run(ASDP_OP_ADC, 32'h1, 32'h2, 1'b0, 4'h1, 4'h5, 1'b1, 1'b0);
    run(ASDP_OP_SUB, 32'h0, 32'h1, 1'b0, 4'h6, 4'h6, 1'b1, 1'b1);
    run(ASDP_OP_SUB_BORROW, 32'h5, 32'h2, 1'b0, 4'h2, 4'h9, 1'b1,
        1'b1);
    run(ASDP_OP_SUB_BORROW, 32'h5, 32'h2, 1'b0, 4'h2, 4'h9, 1'b1,
        1'b1);
    run(ASDP_OP_ADC, 32'h7fff_ffff, 32'h0, 1'b0, 4'h1, 4'h5, 1'b1,
        1'b1);
    idle();
    $display("test chain done");
  endtask : t_chain

  task automatic t_sub();
    run(ASDP_OP_SUB, 32'h8000_0000, 32'h1, 1'b0, 4'h1, 4'h2, 1'b1,
        1'b1);
    run(ASDP_OP_SUB, 32'h300, 32'h0f0, 1'b1, 4'h1, 4'h8, 1'b1, 1'b1);
    run(ASDP_OP_REV_SUB, 32'h4, 32'h500, 1'b0, 4'h4, 4'h4, 1'b1,
        1'b1);
    run(ASDP_OP_REV_SUB, 32'h9, 32'h9, 1'b0, 4'h4, 4'h4, 1'b0,
        1'b1);
    run(ASDP_OP_SUB, 32'h2, 32'h5, 1'b0, 4'h1, 4'h2, 1'b1, 1'b0);
    idle();
    $display("test subtract done");
  endtask : t_sub

  task automatic t_pc();
    run(ASDP_OP_ADD, 32'h1003, 32'h4, 1'b1, 4'hf, 4'h3, 1'b1,
        1'b0);
    run(ASDP_OP_SUB, 32'h2002, 32'h2, 1'b1, 4'hf, 4'h3, 1'b1,
        1'b0);
    run(ASDP_OP_ADD, 32'h2000, 32'h35, 1'b0, 4'hf, 4'hf, 1'b1,
        1'b0);
    run(ASDP_OP_ADD, 32'h1002, 32'h7, 1'b0, 4'hf, 4'hf, 1'b1,
        1'b0);
    idle();
    $display("test program counter done");
  endtask : t_pc

  // reset in mid-run with a request still up: reset wins, carry is cleared
  task automatic t_reset();
    run(ASDP_OP_ADD, 32'hffff_ffff, 32'h1, 1'b0, 4'h1, 4'h2, 1'b1,
        1'b1);
    rst_in = 1'b1;
    @(negedge clk_sys_in);
    check_cleared();
    rst_in = 1'b0;
    req_in.valid = 1'b0;
    exp_f = '0;
    @(negedge clk_sys_in);
    check_cleared();
    run(ASDP_OP_ADC, 32'h1, 32'h2, 1'b0, 4'h1, 4'h5, 1'b1, 1'b0);
    idle();
    $display("test reset done");
  endtask : t_reset

  task automatic test_done();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  initial begin
    miscompares = 0;
    samples_checked = 0;
    exp_f = '0;
    rst_in = 1'b1;
    req_in = '0;
    repeat (12) @(negedge clk_sys_in);
    rst_in = 1'b0;
    check_cleared();
    t_add();
    t_chain();
    t_sub();
    t_pc();
    t_reset();
    test_done();
  end
endmodule : testbench
